// File: hw/sipo_latch_map.svh
// Constants for the serial-in latched parallel-out block
`ifndef SIPO_LATCH_MAP_SVH
`define SIPO_LATCH_MAP_SVH
`define STAGE_COUNT      8
`define STAGE_RESET      8'h00
`define LATCH_RESET      8'h00
`define FIFO_DEPTH       4
`define SYNC_STAGES      3
`endif

// File: hw/sipo_latch_pkg.sv
// Types for the serial-in latched parallel-out block
package sipo_latch_pkg;
  typedef logic [7:0] byte_t;
endpackage

// File: hw/sipo_fifo.sv
// Small FIFO carrying latch snapshots
`timescale 1ns/1ps
module sipo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshakes
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sipo_fifo

// File: hw/sipo_latch.sv
// Serial-in shift register with storage latch and three-state parallel outputs
// What this block does
// - Shift clock rise shifts serial bit in
// - Reset low clears stages, not latch
// - Stages hold without a shift clock rise
// - Latch clock rise copies stages to latch
// - Latch holds without latch clock rise
// - Enable low drives latch bits out
// - Enable high floats outputs, latch kept
// - Cascade output always driven
// - Cascade output shows eighth stage
// - Shift and latch clocks are independent
`timescale 1ns/1ps
`include "sipo_latch_map.svh"
module sipo_latch
  import sipo_latch_pkg::*;
#(
  parameter int WIDTH = `STAGE_COUNT,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             serial_in,
  input  wire logic             shift_clock,
  input  wire logic             latch_clock,
  input  wire logic             stage_reset_n,
  input  wire logic             output_enable_n,
  output logic                  serial_cascade_out,
  output logic      [WIDTH-1:0] parallel_latch_outputs,
  output logic      [WIDTH-1:0] parallel_oe_n,
  output logic                  snap_valid,
  input  wire logic             snap_ready,
  output logic      [WIDTH-1:0] snap_data
);
  // Three-stage synchronisers for the five pins
  logic [2:0] sync_data;
  logic [2:0] sync_sclk;
  logic [2:0] sync_lclk;
  logic [2:0] sync_rst;
  logic [2:0] sync_oe;
  logic       data_q;
  logic       sclk_q;
  logic       lclk_q;
  logic       rstn_q;
  logic       oe_q;
  logic       shift_rise;
  logic       latch_rise;
  logic [WIDTH-1:0] shift_stage_bits;
  logic [WIDTH-1:0] storage_latch_bits;
  logic             fifo_in_ready;

  // Sampling chain; bit 0 is read only by bit 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_data <= 3'h0;
      sync_sclk <= 3'h0;
      sync_lclk <= 3'h0;
      sync_rst  <= 3'h7;
      sync_oe   <= 3'h7;
    end else begin
      sync_data <= {sync_data[1:0], serial_in};
      sync_sclk <= {sync_sclk[1:0], shift_clock};
      sync_lclk <= {sync_lclk[1:0], latch_clock};
      sync_rst  <= {sync_rst[1:0], stage_reset_n};
      sync_oe   <= {sync_oe[1:0], output_enable_n};
    end
  end

  // Accepted levels change once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_q <= 1'b0;
      sclk_q <= 1'b0;
      lclk_q <= 1'b0;
      rstn_q <= 1'b1;
      oe_q   <= 1'b1;
    end else begin
      if (sync_data[1] == sync_data[2]) data_q <= sync_data[2];
      if (sync_sclk[1] == sync_sclk[2]) sclk_q <= sync_sclk[2];
      if (sync_lclk[1] == sync_lclk[2]) lclk_q <= sync_lclk[2];
      if (sync_rst[1] == sync_rst[2])   rstn_q <= sync_rst[2];
      if (sync_oe[1] == sync_oe[2])     oe_q   <= sync_oe[2];
    end
  end

  // Rising edges of the accepted clock levels
  assign shift_rise = (sync_sclk[1] == sync_sclk[2]) && sync_sclk[2] && !sclk_q;
  assign latch_rise = (sync_lclk[1] == sync_lclk[2]) && sync_lclk[2] && !lclk_q;

  // Shift stages: clear wins, else shift on a rise, else hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_stage_bits <= WIDTH'(`STAGE_RESET);
    end else if (!rstn_q) begin
      shift_stage_bits <= WIDTH'(`STAGE_RESET);
    end else if (shift_rise) begin
      shift_stage_bits <= {shift_stage_bits[WIDTH-2:0], data_q};
    end
  end

  // Storage latch: follows only its own clock, untouched by stage reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      storage_latch_bits <= WIDTH'(`LATCH_RESET);
    end else if (latch_rise) begin
      storage_latch_bits <= shift_stage_bits;
    end
  end

  // Pin drivers; enables are low while driving
  assign serial_cascade_out     = shift_stage_bits[WIDTH-1];
  assign parallel_latch_outputs = storage_latch_bits;
  assign parallel_oe_n          = {WIDTH{oe_q}};

  // Snapshot of each latch update queued for the user side; updates that arrive while the queue is full are dropped
  sipo_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (latch_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_stage_bits),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (snap_data)
  );

  // Assertions
  // Shift stage checks
  property p_shift;
    @(posedge clk) disable iff (sys_rst) rstn_q && shift_rise |=>
      shift_stage_bits == {$past(shift_stage_bits[WIDTH-2:0]), $past(data_q)};
  endproperty
  a_shift: assert property (p_shift) else $error("stage shift wrong");

  property p_rise_once;
    @(posedge clk) disable iff (sys_rst) shift_rise |=> !shift_rise;
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("shift edge seen twice");

  property p_clear;
    @(posedge clk) disable iff (sys_rst) !rstn_q |=> shift_stage_bits == '0 && !serial_cascade_out;
  endproperty
  a_clear: assert property (p_clear) else $error("stage clear wrong");

  property p_clear_keeps_latch;
    @(posedge clk) disable iff (sys_rst) !rstn_q && !latch_rise |=> $stable(storage_latch_bits);
  endproperty
  a_clear_keeps_latch: assert property (p_clear_keeps_latch) else $error("clear touched latch");

  property p_hold_stage;
    @(posedge clk) disable iff (sys_rst) rstn_q && !shift_rise |=> $stable(shift_stage_bits);
  endproperty
  a_hold_stage: assert property (p_hold_stage) else $error("stages moved");

  property p_stage_ignores_latch;
    @(posedge clk) disable iff (sys_rst) rstn_q && latch_rise && !shift_rise |=> $stable(shift_stage_bits);
  endproperty
  a_stage_ignores_latch: assert property (p_stage_ignores_latch) else $error("latch clock moved stages");

  // Latch checks
  property p_latch;
    @(posedge clk) disable iff (sys_rst) latch_rise |=> storage_latch_bits == $past(shift_stage_bits);
  endproperty
  a_latch: assert property (p_latch) else $error("latch copy wrong");

  property p_latch_rise_once;
    @(posedge clk) disable iff (sys_rst) latch_rise |=> !latch_rise;
  endproperty
  a_latch_rise_once: assert property (p_latch_rise_once) else $error("latch edge seen twice");

  property p_snap_push;
    @(posedge clk) disable iff (sys_rst) latch_rise && !snap_valid |=>
      snap_valid && snap_data == $past(shift_stage_bits);
  endproperty
  a_snap_push: assert property (p_snap_push) else $error("snapshot not queued");

  property p_hold_latch;
    @(posedge clk) disable iff (sys_rst) !latch_rise |=> $stable(storage_latch_bits);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("latch moved");

  property p_indep;
    @(posedge clk) disable iff (sys_rst) shift_rise && !latch_rise |=> $stable(parallel_latch_outputs);
  endproperty
  a_indep: assert property (p_indep) else $error("shift disturbed outputs");

  // Pin driver checks
  property p_drive;
    @(posedge clk) disable iff (sys_rst) !oe_q |-> parallel_oe_n == '0 &&
      parallel_latch_outputs == storage_latch_bits;
  endproperty
  a_drive: assert property (p_drive) else $error("outputs not driven");

  property p_float;
    @(posedge clk) disable iff (sys_rst) oe_q |-> parallel_oe_n == '1;
  endproperty
  a_float: assert property (p_float) else $error("outputs not floated");

  property p_float_keeps_latch;
    @(posedge clk) disable iff (sys_rst) oe_q && !latch_rise |=> $stable(storage_latch_bits);
  endproperty
  a_float_keeps_latch: assert property (p_float_keeps_latch) else $error("float lost latch");

  property p_cascade;
    @(posedge clk) disable iff (sys_rst) rstn_q && shift_rise |=>
      serial_cascade_out == $past(shift_stage_bits[WIDTH-2]);
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade wrong");

  property p_cascade_no_oe;
    @(posedge clk) disable iff (sys_rst) $changed(oe_q) && rstn_q && !shift_rise |=>
      $stable(serial_cascade_out);
  endproperty
  a_cascade_no_oe: assert property (p_cascade_no_oe) else $error("enable moved cascade");

  // Main scenarios
  c_shift: cover property (@(posedge clk) disable iff (sys_rst) rstn_q && shift_rise);
  c_latch: cover property (@(posedge clk) disable iff (sys_rst) latch_rise);
  c_clear: cover property (@(posedge clk) disable iff (sys_rst) $fell(rstn_q));
  c_full:  cover property (@(posedge clk) disable iff (sys_rst) !fifo_in_ready);
  c_float: cover property (@(posedge clk) disable iff (sys_rst) oe_q && latch_rise);
endmodule // sipo_latch

// File: testbench/host_model.sv
// Host serial controller model that drives the pins of the block
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,
  output logic      serial_in,
  output logic      shift_clock,
  output logic      latch_clock,
  output logic      stage_reset_n,
  output logic      output_enable_n
);
  // Clocks stand low between transfers, outputs start floated
  initial begin
    serial_in       = 1'b0;
    shift_clock     = 1'b0;
    latch_clock     = 1'b0;
    stage_reset_n   = 1'b1;
    output_enable_n = 1'b1;
  end
  // Waits n rising edges, then steps just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit: data settles, clock rises, data held, then data goes stale
  task automatic shift_bit(input logic b);
    serial_in = b;
    step(5);
    shift_clock = 1'b1;
    step(6);
    shift_clock = 1'b0;
    serial_in = ~b; // Hold time over, line no longer shows the bit
    step(5);
  endtask
  // One latch clock pulse, long enough for the pin samplers
  task automatic pulse_latch();
    latch_clock = 1'b1;
    step(6);
    latch_clock = 1'b0;
    step(6);
  endtask
  // Level pins, given time to pass the samplers
  task automatic set_oe(input logic v);
    output_enable_n = v;
    step(6);
  endtask
  task automatic set_clear(input logic v);
    stage_reset_n = v;
    step(6);
  endtask
endmodule // host_model

// File: testbench/sipo_latch_tb.sv
// Self-checking bench for the serial-in latched parallel-out block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module sipo_latch_tb;
  import sipo_latch_pkg::*;
  logic  clk, sys_rst, snap_ready, serial_in, shift_clock, latch_clock;
  logic  stage_reset_n, output_enable_n, serial_cascade_out, snap_valid;
  byte_t parallel_latch_outputs, parallel_oe_n, snap_data, exp_stage;
  int    err_count = 0;
  int    checks = 0;
  int    cycles = 0;
  sipo_latch u_sipo_latch (.clk(clk), .sys_rst(sys_rst), .serial_in(serial_in), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .stage_reset_n(stage_reset_n), .output_enable_n(output_enable_n),
    .serial_cascade_out(serial_cascade_out), .parallel_latch_outputs(parallel_latch_outputs),
    .parallel_oe_n(parallel_oe_n), .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data));
  host_model u_host_model (.clk(clk), .serial_in(serial_in), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .stage_reset_n(stage_reset_n), .output_enable_n(output_enable_n));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Shifts a byte first bit first, following the cascade pin per bit
  task automatic send_byte(input byte_t b);
    for (int i = 7; i >= 0; i--) begin
      u_host_model.shift_bit(b[i]);
      exp_stage = {exp_stage[6:0], b[i]};
      `CHK(serial_cascade_out, exp_stage[7])
    end
  endtask
  task automatic t_shift_latch;
    u_host_model.set_oe(1'b0);
    `CHK(parallel_oe_n, 8'h00)
    send_byte(8'hA5);
    `CHK(parallel_latch_outputs, 8'h00)
    u_host_model.pulse_latch();
    `CHK(parallel_latch_outputs, 8'hA5)
  endtask
  // Clear blocks a shift and leaves the latch alone
  task automatic t_clear;
    u_host_model.set_clear(1'b0);
    u_host_model.shift_bit(1'b1);
    `CHK(serial_cascade_out, 1'b0)
    `CHK(parallel_latch_outputs, 8'hA5)
    u_host_model.set_clear(1'b1);
    exp_stage = 8'h00;
    u_host_model.pulse_latch();
    `CHK(parallel_latch_outputs, 8'h00)
  endtask
  // Floated outputs keep the latch, cascade keeps shifting
  task automatic t_enable;
    u_host_model.set_oe(1'b1);
    `CHK(parallel_oe_n, 8'hFF)
    send_byte(8'h81);
    `CHK(parallel_latch_outputs, 8'h00)
    u_host_model.set_oe(1'b0);
    `CHK(parallel_oe_n, 8'h00)
  endtask
  // Five latches into a four-deep snapshot queue, then drain
  task automatic t_fifo;
    byte_t vals[5] = '{8'h3C, 8'hC3, 8'h5A, 8'h96, 8'h0F};
    `CHK(snap_valid, 1'b0)
    snap_ready = 1'b0;
    foreach (vals[i]) begin
      send_byte(vals[i]);
      u_host_model.pulse_latch();
    end
    `CHK(parallel_latch_outputs, 8'h0F)
    for (int i = 0; i < 4; i++) begin
      `CHK(snap_valid, 1'b1)
      `CHK(snap_data, vals[i])
      snap_ready = snap_valid;
      @(posedge clk);
      #1;
    end
    snap_ready = 1'b0;
    `CHK(snap_valid, 1'b0)
  endtask
  // Reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    snap_ready = 1'b1;
    exp_stage = 8'h00;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    `CHK(parallel_oe_n, 8'hFF)
    `CHK(serial_cascade_out, 1'b0)
    t_shift_latch();
    t_clear();
    t_enable();
    t_fifo();
    summarize();
  end
endmodule // sipo_latch_tb
